// [rtl/peq_cfg.svh]
// Event codes, widths and reset values of the event qualifier
`ifndef PEQ_CFG_SVH
`define PEQ_CFG_SVH
`define PEQ_EVT_FP_OP 6'h22
`define PEQ_EVT_BP0 6'h23
`define PEQ_EVT_BP1 6'h24
`define PEQ_EVT_BP2 6'h25
`define PEQ_EVT_BP3 6'h26
`define PEQ_EVT_HW_INT 6'h27
`define PEQ_EVT_DATA_RW 6'h28
`define PEQ_EVT_DATA_MISS 6'h29
`define PEQ_EVT_BUS_OWN 6'h2a
`define PEQ_EVT_PKD_INT 6'h2b
`define PEQ_EVT_RST 6'h00
`define PEQ_CNT_RST 40'h00_0000_0000
`define PEQ_BURST_BEATS 3'h4
`define PEQ_BUS_IDLE 5'h0d
`endif

// [rtl/peq_pkg.sv]
// Types shared by the event qualifier files
package peq_pkg;
  typedef logic [5:0] peq_code_t;
  typedef logic [39:0] peq_count_t;
  typedef logic [1:0] peq_inc_t;

  // Occurrence strobes from pipelines, cache and bus controller
  typedef struct packed {
    logic [1:0] fp_op;        // FPU operations finished this clock
    logic [1:0] fp_exc_skip;  // Of those, excluded exception kinds
    logic [3:0] bp_match_u;   // Breakpoint matches, U-pipe
    logic [3:0] bp_match_v;   // Breakpoint matches, V-pipe
    logic bp_enabled;         // Any breakpoint enabled
    logic maskable_interrupt_request_taken;         // Maskable interrupt taken
    logic nmi_taken;          // Non-maskable interrupt taken
    logic [1:0] data_acc;     // Memory data accesses, split halves each
    logic [1:0] data_miss;    // Of those, data cache misses
    logic [1:0] data_line_hit_fill; // Miss hitting line under fill
    logic tlb_walk;           // Accesses belong to TLB miss work
    logic io_space;           // Accesses go to I/O space
    logic fill_start;         // Burst line fill begins
    logic [1:0] pkd_u;        // Packed-integer ops in U-pipe
  } peq_evt_t;

  // Private bus pins seen by the qualifier, synchronised
  typedef struct packed {
    logic private_bus_request;
    logic private_hit_modified_n;
    logic hit_modified_n;
    logic private_bus_grant;
    logic burst_ready_n;
  } peq_bus_t;
endpackage

// [rtl/peq_counter.sv]
// One event counter adding a qualified increment each clock
`timescale 1ns/10ps
`default_nettype none
`include "peq_cfg.svh"
module peq_counter
  import peq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire peq_inc_t inc_i,
  output peq_count_t count_o
);
  peq_count_t count_r;
  peq_count_t count_nxt;

  // Add up to two per clock
  always_comb begin
    count_nxt = count_r;
    if (clear_i) begin
      count_nxt = `PEQ_CNT_RST;
    end else begin
      count_nxt = count_r + {38'h0, inc_i};
    end
  end

  // Count register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= `PEQ_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_o = count_r;
endmodule
`default_nettype wire

// [rtl/peq_top.sv]
// Event qualification for two performance counters, codes 22h to 2bh
`timescale 1ns/10ps
`default_nettype none
`include "peq_cfg.svh"
module peq_top
  import peq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire peq_code_t sel0_i,
  input wire peq_code_t sel1_i,
  input wire logic sel_load_i,
  input wire logic clear_i,
  input wire peq_evt_t evt_i,
  input wire peq_bus_t bus_pins_i,
  output logic [3:0] breakpoint_match_pins_o,
  output peq_code_t sel0_o,
  output peq_code_t sel1_o,
  output peq_count_t count0_o,
  output peq_count_t count1_o
);
  // Two-bit population count, shared by all double events
  function automatic peq_inc_t pop2(input logic [1:0] v);
    pop2 = {1'b0, v[0]} + {1'b0, v[1]};
  endfunction

  // Synchroniser for the bus pins
  peq_bus_t sync1_r;
  peq_bus_t sync2_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= `PEQ_BUS_IDLE; // No request, low-active lines high, no grant
      sync2_r <= `PEQ_BUS_IDLE;
    end else begin
      sync1_r <= bus_pins_i;
      sync2_r <= sync1_r;
    end
  end

  // Pin state registers for edges and latency
  logic req_prev_r;
  logic req_prev_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [2:0] beats_r;
  logic [2:0] beats_nxt;
  logic filling_r;
  logic filling_nxt;
  logic own_req;
  logic req_rise;
  logic fill_cut;

  // Bus ownership request as the earliest of three
  always_comb begin
    own_req = sync2_r.private_bus_request | ~sync2_r.private_hit_modified_n
      | ~sync2_r.hit_modified_n;
    req_rise = sync2_r.private_bus_request & ~req_prev_r;
    req_prev_nxt = sync2_r.private_bus_request;
    wait_nxt = wait_r;
    if (sync2_r.private_bus_grant) begin
      wait_nxt = 1'b0;
    end else if (own_req) begin
      wait_nxt = 1'b1;
    end
  end

  // Burst fill tracking by burst-ready beats
  always_comb begin
    beats_nxt = beats_r;
    filling_nxt = filling_r;
    if (evt_i.fill_start && !filling_r) begin
      filling_nxt = 1'b1;
      beats_nxt = 3'h0;
    end else if (filling_r && !sync2_r.burst_ready_n) begin
      beats_nxt = beats_r + 3'h1;
      if (beats_r + 3'h1 == `PEQ_BURST_BEATS) begin
        filling_nxt = 1'b0;
      end
    end
    // Same-line misses held back from the first beat on
    fill_cut = filling_r & (beats_r != 3'h0);
  end

  // Bus ownership registers, idle after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_prev_r <= 1'b0;
      wait_r <= 1'b0;
    end else begin
      req_prev_r <= req_prev_nxt;
      wait_r <= wait_nxt;
    end
  end

  // Burst fill registers, no fill after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beats_r <= 3'h0;
      filling_r <= 1'b0;
    end else begin
      beats_r <= beats_nxt;
      filling_r <= filling_nxt;
    end
  end

  // Both halves dropped when the access is excluded
  function automatic peq_inc_t pop2_kept(input logic [1:0] v, input logic drop);
    pop2_kept = drop ? 2'h0 : pop2(v);
  endfunction

  // Qualified occurrence counts per event
  logic [1:0] fp_kept;
  peq_inc_t fp_inc;
  logic [3:0] bp_v_kept;
  logic [3:0] bp_qual;
  peq_inc_t int_inc;
  peq_inc_t rw_inc;
  peq_inc_t miss_inc;
  logic lat_clk;
  logic [1:0] miss_v;
  logic excl;

  // FPU, breakpoint and interrupt qualification
  always_comb begin
    // FPU strobes already carry each internal step and integer multiply
    fp_kept = evt_i.fp_op & ~evt_i.fp_exc_skip;
    fp_inc = pop2(fp_kept);
    // V-pipe matches only while breakpoints are enabled
    bp_v_kept = evt_i.bp_enabled ? evt_i.bp_match_v : 4'h0;
    bp_qual = evt_i.bp_match_u | bp_v_kept;
    int_inc = pop2({evt_i.maskable_interrupt_request_taken, evt_i.nmi_taken});
  end

  // Data access and miss qualification
  always_comb begin
    excl = evt_i.tlb_walk | evt_i.io_space;
    rw_inc = pop2_kept(evt_i.data_acc, excl);
    // Same-line misses add nothing between first and fourth beat
    miss_v = evt_i.data_miss & ~(fill_cut ? evt_i.data_line_hit_fill : 2'h0);
    miss_inc = pop2_kept(miss_v, excl);
  end

  // Ownership latency clock, grant clock itself not counted
  always_comb begin
    lat_clk = (wait_r | own_req) & ~sync2_r.private_bus_grant;
  end

  // Breakpoint match pins, registered
  logic [3:0] bp_pins_r;
  logic [3:0] bp_pins_nxt;
  always_comb begin
    bp_pins_nxt = bp_qual;
  end

  // Selected event code registers
  peq_code_t sel0_r;
  peq_code_t sel0_nxt;
  peq_code_t sel1_r;
  peq_code_t sel1_nxt;
  always_comb begin
    sel0_nxt = sel_load_i ? sel0_i : sel0_r;
    sel1_nxt = sel_load_i ? sel1_i : sel1_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bp_pins_r <= 4'h0;
      sel0_r <= `PEQ_EVT_RST;
      sel1_r <= `PEQ_EVT_RST;
    end else begin
      bp_pins_r <= bp_pins_nxt;
      sel0_r <= sel0_nxt;
      sel1_r <= sel1_nxt;
    end
  end

  // Event decode, counter index steers code 2ah and 2bh
  function automatic peq_inc_t pick(input peq_code_t code, input logic idx,
                                    input peq_inc_t fp, input logic [3:0] bp,
                                    input peq_inc_t maskable_interrupt_request, input peq_inc_t rw,
                                    input peq_inc_t ms, input logic lat,
                                    input logic rise, input peq_inc_t pk);
    case (code)
      `PEQ_EVT_FP_OP: pick = fp;
      `PEQ_EVT_BP0: pick = {1'b0, bp[0]};
      `PEQ_EVT_BP1: pick = {1'b0, bp[1]};
      `PEQ_EVT_BP2: pick = {1'b0, bp[2]};
      `PEQ_EVT_BP3: pick = {1'b0, bp[3]};
      `PEQ_EVT_HW_INT: pick = maskable_interrupt_request;
      `PEQ_EVT_DATA_RW: pick = rw;
      `PEQ_EVT_DATA_MISS: pick = ms;
      `PEQ_EVT_BUS_OWN: pick = idx ? {1'b0, rise} : {1'b0, lat};
      `PEQ_EVT_PKD_INT: pick = idx ? 2'h0 : pk;
      default: pick = 2'h0;
    endcase
  endfunction

  peq_inc_t inc0;
  peq_inc_t inc1;
  always_comb begin
    inc0 = pick(sel0_r, 1'b0, fp_inc, bp_qual, int_inc, rw_inc, miss_inc, lat_clk,
                req_rise, pop2(evt_i.pkd_u));
    inc1 = pick(sel1_r, 1'b1, fp_inc, bp_qual, int_inc, rw_inc, miss_inc, lat_clk,
                req_rise, pop2(evt_i.pkd_u));
  end

  // The two counters
  peq_counter u_cnt0 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clear_i),
    .inc_i(inc0),
    .count_o(count0_o)
  );
  peq_counter u_cnt1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clear_i),
    .inc_i(inc1),
    .count_o(count1_o)
  );

  assign breakpoint_match_pins_o = bp_pins_r;
  assign sel0_o = sel0_r;
  assign sel1_o = sel1_r;
endmodule
`default_nettype wire

// [tb/peq_props.sv]
// Port assertions for the event qualifier
`timescale 1ns/10ps
`default_nettype none
module peq_props
  import peq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire peq_code_t sel0_i,
  input wire peq_code_t sel1_i,
  input wire logic sel_load_i,
  input wire logic clear_i,
  input wire peq_evt_t evt_i,
  input wire logic [3:0] breakpoint_match_pins_o,
  input wire peq_code_t sel0_o,
  input wire peq_code_t sel1_o,
  input wire peq_count_t count0_o,
  input wire peq_count_t count1_o
);
  // One domain, reset disables all
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic run = !clear_i;
  // Count and code relations
  a_clear_zero: assert property (clear_i |=> count0_o == '0 && count1_o == '0)
    else $error("clear missed");
  a_code_load: assert property (sel_load_i |=> sel0_o == $past(sel0_i)
    && sel1_o == $past(sel1_i)) else $error("code not loaded");
  a_fp_add: assert property (run && sel0_o == 6'h22 |=> count0_o == $past(count0_o)
    + 40'($countones($past(evt_i.fp_op & ~evt_i.fp_exc_skip)))) else $error("fp count");
  a_int_add: assert property (run && sel1_o == 6'h27 |=> count1_o == $past(count1_o)
    + 40'($countones($past({evt_i.maskable_interrupt_request_taken, evt_i.nmi_taken})))) else $error("int count");
  a_rw_add: assert property (run && sel0_o == 6'h28 && !evt_i.tlb_walk
    && !evt_i.io_space |=> count0_o == $past(count0_o) + 40'($countones($past(evt_i.data_acc))))
    else $error("rw count");
  a_rw_excl: assert property (run && sel0_o == 6'h28
    && (evt_i.tlb_walk || evt_i.io_space) |=> $stable(count0_o)) else $error("rw excl");
  a_pin_mirror: assert property (1'b1 |=> breakpoint_match_pins_o ==
    $past(evt_i.bp_match_u | evt_i.bp_match_v & {4{evt_i.bp_enabled}})) else $error("pins");
  a_bp_pin_cnt: assert property (run && sel1_o == 6'h23 |=> count1_o ==
    $past(count1_o) + 40'(breakpoint_match_pins_o[0])) else $error("bp count");
  a_pkd_none: assert property (run && sel1_o == 6'h2b |=> $stable(count1_o))
    else $error("2b on ctr1");
  // Main scenarios reached
  c_latency: cover property (sel0_o == 6'h2a && count0_o > 40'h5);
  c_rw_pair: cover property (sel0_o == 6'h28 && count0_o == 40'h2);
  c_fill: cover property (sel0_o == 6'h29 && count0_o != '0);
endmodule
bind peq_top peq_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel0_i(sel0_i),
  .sel1_i(sel1_i), .sel_load_i(sel_load_i), .clear_i(clear_i), .evt_i(evt_i),
  .breakpoint_match_pins_o(breakpoint_match_pins_o), .sel0_o(sel0_o), .sel1_o(sel1_o),
  .count0_o(count0_o), .count1_o(count1_o));
`default_nettype wire

// [tb/peq_bus_model.sv]
// Bus controller model driving the private bus pins
`timescale 1ns/10ps
`default_nettype none
module peq_bus_model
  import peq_pkg::*;
(
  input wire logic clk_i,
  output var peq_bus_t bus_o
);
  // Idle: no request or grant, low-active lines high
  initial bus_o = 5'h0d;
  // Request, grant after gap clocks, then release
  task automatic own(input int gap);
    @(posedge clk_i);
    bus_o.private_bus_request <= 1'b1;
    repeat (gap) @(posedge clk_i);
    bus_o.private_bus_grant <= 1'b1;
    @(posedge clk_i);
    bus_o.private_bus_request <= 1'b0;
    bus_o.private_bus_grant <= 1'b0;
  endtask
  // Hit-modified on one line, grant after gap clocks, then release
  task automatic snoop(input bit priv, input int gap);
    @(posedge clk_i);
    if (priv) begin
      bus_o.private_hit_modified_n <= 1'b0;
    end else begin
      bus_o.hit_modified_n <= 1'b0;
    end
    repeat (gap) @(posedge clk_i);
    bus_o.private_bus_grant <= 1'b1;
    @(posedge clk_i);
    bus_o.private_hit_modified_n <= 1'b1;
    bus_o.hit_modified_n <= 1'b1;
    bus_o.private_bus_grant <= 1'b0;
  endtask
  // Four burst-ready beats of a line fill
  task automatic fill;
    repeat (4) begin
      @(posedge clk_i);
      bus_o.burst_ready_n <= 1'b0;
      @(posedge clk_i);
      bus_o.burst_ready_n <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// [tb/peq_top_tb.sv]
// Self-checking bench of the event qualifier
`timescale 1ns/10ps
`default_nettype none
module peq_top_tb import peq_pkg::*;;
  logic clk_i = 0;
  logic rst_n_i = 0;
  peq_code_t s0 = '0, s1 = '0;
  logic ld = 0, clr = 0;
  peq_evt_t ev = '0;
  peq_bus_t bus;
  peq_count_t c0, c1;
  int n_fail = 0, check_count = 0;
  // Clock and units
  initial forever #10 clk_i = ~clk_i;
  peq_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel0_i(s0), .sel1_i(s1), .sel_load_i(ld),
    .clear_i(clr), .evt_i(ev), .bus_pins_i(bus), .breakpoint_match_pins_o(), .sel0_o(),
    .sel1_o(), .count0_o(c0), .count1_o(c1));
  peq_bus_model pm (.clk_i(clk_i), .bus_o(bus));
  // Load both codes and clear counts
  task automatic sel(input peq_code_t a, input peq_code_t b);
    @(posedge clk_i);
    s0 <= a;
    s1 <= b;
    ld <= 1;
    clr <= 1;
    @(posedge clk_i);
    ld <= 0;
    clr <= 0;
  endtask
  // One clock of strobes
  task automatic put(input peq_evt_t v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= '0;
  endtask
  task automatic chk(input peq_count_t got, input peq_count_t exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t count %0h want %0h", $time, got, exp);
    end
  endtask
  // Let sync stages drain, then compare both counters
  task automatic done(input peq_count_t e0, input peq_count_t e1);
    repeat (4) @(posedge clk_i);
    #1;
    chk(c0, e0);
    chk(c1, e1);
  endtask
  task automatic t_fp;
    peq_evt_t v;
    v = '0;
    v.fp_op = 2'h3;
    v.fp_exc_skip = 2'h1;
    v.maskable_interrupt_request_taken = 1;
    v.nmi_taken = 1;
    sel(6'h22, 6'h27);
    repeat (3) put(v);
    done(40'h3, 40'h6);
  endtask
  task automatic t_bp;
    peq_evt_t v;
    for (int i = 0; i < 4; i++) begin
      sel(6'h23 + 6'(i), 6'h23 + 6'(i));
      v = '0;
      v.bp_match_u[i] = 1;
      put(v);
      v = '0;
      v.bp_match_v[i] = 1;
      put(v);
      v.bp_enabled = 1;
      put(v);
      v = '0;
      v.bp_match_u = ~(4'h1 << i);
      put(v);
      done(40'h2, 40'h2);
    end
  endtask
  task automatic t_rw;
    peq_evt_t v;
    v = '0;
    v.data_acc = 2'h3;
    v.data_miss = 2'h1;
    sel(6'h28, 6'h29);
    put(v);
    v.tlb_walk = 1;
    put(v);
    v.tlb_walk = 0;
    v.io_space = 1;
    put(v);
    done(40'h2, 40'h1);
  endtask
  // Same-line misses: counted before first beat, held back after it, counted after fill
  task automatic t_fill;
    peq_evt_t v;
    peq_evt_t f;
    f = '0;
    f.fill_start = 1;
    v = '0;
    v.data_acc = 2'h3;
    v.data_miss = 2'h3;
    v.data_line_hit_fill = 2'h1;
    v.pkd_u = 2'h3;
    sel(6'h29, 6'h2b);
    put(f);
    put(v);
    fork
      pm.fill();
      begin
        repeat (4) @(posedge clk_i);
        put(v);
      end
    join
    repeat (2) @(posedge clk_i);
    put(v);
    done(40'h5, 40'h0);
  endtask
  task automatic t_bus;
    sel(6'h2a, 6'h2a);
    pm.own(1);
    pm.own(5);
    pm.snoop(1'b0, 3);
    pm.snoop(1'b1, 2);
    done(40'hb, 40'h2);
  endtask
  // Packed-integer ops on counter 0, unknown code on counter 1
  task automatic t_pkd;
    peq_evt_t v;
    v = '0;
    v.pkd_u = 2'h3;
    v.fp_op = 2'h3;
    sel(6'h2b, 6'h21);
    put(v);
    v.pkd_u = 2'h2;
    put(v);
    done(40'h3, 40'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Reset, then scenarios
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1;
    t_fp;
    t_bp;
    t_rw;
    t_fill;
    t_bus;
    t_pkd;
    wrap_up;
  end
  // Watchdog
  initial begin
    #50000;
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
